// File: logic/csir_regs.sv
// Charger status, event flags, event enables and current-limit selection.
// Assumes status levels come straight from analog pins and that the
// register port is driven by logic on clk_in.
// How it works
// - Status-two bit 1 reads 1 while thermistor sensing is off.
// - Status-two bit 4 shows charging, bit 5 shows charge complete.
// - Status-two bit 6 shows rail below 3.6V, bit 7 die overheat.
// - Event bit 0 sets on adapter change, write one clears.
// - Event bit 1 sets on limiting change, write one clears, zero keeps.
// - Event bit 2 sets only on charge-complete rising edge; write one clears.
// - Enable bits 0 to 2; after reset adapter enable 1, others 0.
// - Limit source bit high selects internal field, low selects the pin.
// - Pin selection gives 500mA when low, 1.5A when high.
// - Start-up forces 100mA; settled rail uses the register setting.
// - Instant-on disable low: charging off while rail below 3.6V.
// - Instant-on off with load over limit: reduce charge while rail low.
// - Pre-regulator runs only while input is above lockout.
// - Status-one bit 0 holds adapter present, source of event bit 0.
// - Status-one bit 7 holds input limiting, source of event bit 1.
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for one asynchronous level
module csir_sync (
	input  wire logic clk_in,    // Clock
	input  wire logic arst_n_in, // Async reset, active low
	input  wire logic ce_in,     // Clock enable
	input  wire logic async_in,  // Level from a pin
	output logic      sync_out   // Level in clk_in domain
);
	logic meta_reg;
	logic meta_next;
	logic stable_reg;
	logic stable_next;

	// First stage feeds only the second stage
	always_comb begin
		meta_next   = ce_in ? async_in : meta_reg;
		stable_next = ce_in ? meta_reg : stable_reg;
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			meta_reg   <= 1'b0;
			stable_reg <= 1'b0;
		end else begin
			meta_reg   <= meta_next;
			stable_reg <= stable_next;
		end
	end

	assign sync_out = stable_reg;
endmodule // csir_sync

module csir_regs
	import csir_pkg::*;
(
	input  wire logic                  clk_in,              // 250 MHz clock
	input  wire logic                  arst_n_in,           // Async reset, active low
	input  wire logic                  ce_in,               // Clock enable, freezes all state when low
	input  wire csir_pkg::csir_status_t status_in,          // Raw analog status levels
	input  wire csir_pkg::csir_req_t   req_in,              // Local register request
	output logic [7:0]                 rd_data_out,         // Read data, registered
	output logic                       rd_valid_out,        // Read data valid pulse
	output logic                       irq_out,             // Charger interrupt request
	output csir_pkg::csir_limit_mode_t limit_mode_out,      // Selected input limit source
	output logic [2:0]                 limit_field_out,     // Internal limit field value
	output logic                       charge_disable_out,  // Charging disabled by rail sag
	output logic                       charge_reduce_out,   // Charge current reduced
	output logic                       prereg_run_out       // Pre-regulator run enable
);
	import csir_pkg::*;

	csir_status_t st;

	// Every analog level crosses two flops before use
	genvar gi;
	generate
		for (gi = 0; gi < CSIR_STATUS_W; gi++) begin : g_sync
			csir_sync u_sync (
				.clk_in    (clk_in),
				.arst_n_in (arst_n_in),
				.ce_in     (ce_in),
				.async_in  (status_in[gi]),
				.sync_out  (st[gi])
			);
		end
	endgenerate

	logic [7:0] limit_cfg_reg;
	logic [7:0] limit_cfg_next;
	logic [7:0] special_reg;
	logic [7:0] special_next;
	logic [2:0] flags_reg;
	logic [2:0] flags_next;
	logic [4:0] flags_rsvd_reg;
	logic [4:0] flags_rsvd_next;
	logic [2:0] enables_reg;
	logic [2:0] enables_next;
	logic [4:0] enables_rsvd_reg;
	logic [4:0] enables_rsvd_next;
	logic       prev_adapter_reg;
	logic       prev_adapter_next;
	logic       prev_limiting_reg;
	logic       prev_limiting_next;
	logic       prev_complete_reg;
	logic       prev_complete_next;
	logic [1:0] prime_cnt_reg;
	logic [1:0] prime_cnt_next;
	logic       primed;
	logic [7:0] rd_data_reg;
	logic [7:0] rd_data_next;
	logic       rd_valid_reg;
	logic       rd_valid_next;
	logic [7:0] status_one;
	logic [7:0] status_two;
	logic [2:0] events;
	logic [2:0] clears;
	logic       wr_limit;
	logic       wr_special;
	logic       wr_flags;
	logic       wr_enables;

	// Live status words, no storage so they always show the present level
	always_comb begin
		status_one = 8'h00;
		status_two = 8'h00;
		status_one[CSIR_ST1_ADAPTER_BIT]   = st.adapter_present;
		status_one[CSIR_ST1_LIMITING_BIT]  = st.input_limiting_active;
		status_two[CSIR_ST2_SWELL_BIT]     = st.swell_guard_discharging;
		status_two[CSIR_ST2_THERM_OFF_BIT] = st.thermistor_sense_off;
		status_two[CSIR_ST2_IN_PROG_BIT]   = st.charge_in_progress;
		status_two[CSIR_ST2_COMPLETE_BIT]  = st.charge_complete;
		status_two[CSIR_ST2_RAIL_LOW_BIT]  = st.system_rail_low;
		status_two[CSIR_ST2_OVERHEAT_BIT]  = st.die_overheat;
	end

	// Write decode; status and reserved addresses take no write
	assign wr_limit   = req_in.wr_en && (req_in.addr == CSIR_ADDR_LIMIT_CFG);
	assign wr_special = req_in.wr_en && (req_in.addr == CSIR_ADDR_SPECIAL_CTL);
	assign wr_flags   = req_in.wr_en && (req_in.addr == CSIR_ADDR_FLAGS);
	assign wr_enables = req_in.wr_en && (req_in.addr == CSIR_ADDR_ENABLES);

	// Change detection waits until both sync stages and the previous-level flops hold
	// real levels; otherwise every input already high at power-up would raise a flag
	assign primed = (prime_cnt_reg == 2'(CSIR_SYNC_STAGES + 1));

	always_comb begin
		events = 3'h0;
		events[CSIR_FLAG_ADAPTER_BIT]  = primed && (st.adapter_present != prev_adapter_reg);
		events[CSIR_FLAG_LIMIT_BIT]    = primed && (st.input_limiting_active != prev_limiting_reg);
		events[CSIR_FLAG_COMPLETE_BIT] = primed && st.charge_complete && !prev_complete_reg;
		clears = wr_flags ? req_in.wr_data[2:0] : 3'h0;
	end

	// Next values of control and flag state; a set in the clear cycle wins
	always_comb begin
		limit_cfg_next     = limit_cfg_reg;
		special_next       = special_reg;
		flags_next         = flags_reg;
		flags_rsvd_next    = flags_rsvd_reg;
		enables_next       = enables_reg;
		enables_rsvd_next  = enables_rsvd_reg;
		prev_adapter_next  = prev_adapter_reg;
		prev_limiting_next = prev_limiting_reg;
		prev_complete_next = prev_complete_reg;
		prime_cnt_next     = prime_cnt_reg;
		if (ce_in) begin
			if (wr_limit) begin
				limit_cfg_next = req_in.wr_data;
			end
			if (wr_special) begin
				special_next = req_in.wr_data;
			end
			flags_next = (flags_reg & ~clears) | events;
			if (wr_flags) begin
				flags_rsvd_next = req_in.wr_data[7:3];
			end
			if (wr_enables) begin
				enables_next      = req_in.wr_data[2:0];
				enables_rsvd_next = req_in.wr_data[7:3];
			end
			prev_adapter_next  = st.adapter_present;
			prev_limiting_next = st.input_limiting_active;
			prev_complete_next = st.charge_complete;
			if (!primed) begin
				prime_cnt_next = prime_cnt_reg + 2'h1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			limit_cfg_reg     <= CSIR_LIMIT_CFG_RESET;
			special_reg       <= CSIR_SPECIAL_CTL_RESET;
			flags_reg         <= CSIR_FLAGS_RESET;
			flags_rsvd_reg    <= CSIR_RSVD_RESET;
			enables_reg       <= CSIR_ENABLES_RESET;
			enables_rsvd_reg  <= CSIR_RSVD_RESET;
			prev_adapter_reg  <= 1'b0;
			prev_limiting_reg <= 1'b0;
			prev_complete_reg <= 1'b0;
			prime_cnt_reg     <= 2'h0;
		end else begin
			limit_cfg_reg     <= limit_cfg_next;
			special_reg       <= special_next;
			flags_reg         <= flags_next;
			flags_rsvd_reg    <= flags_rsvd_next;
			enables_reg       <= enables_next;
			enables_rsvd_reg  <= enables_rsvd_next;
			prev_adapter_reg  <= prev_adapter_next;
			prev_limiting_reg <= prev_limiting_next;
			prev_complete_reg <= prev_complete_next;
			prime_cnt_reg     <= prime_cnt_next;
		end
	end

	// Read mux; reserved and unmapped addresses answer zero
	always_comb begin
		rd_data_next  = rd_data_reg;
		rd_valid_next = 1'b0;
		if (ce_in) begin
			rd_valid_next = req_in.rd_en;
			if (req_in.rd_en) begin
				case (req_in.addr)
					CSIR_ADDR_LIMIT_CFG:   rd_data_next = limit_cfg_reg;
					CSIR_ADDR_SPECIAL_CTL: rd_data_next = special_reg;
					CSIR_ADDR_STATUS_ONE:  rd_data_next = status_one;
					CSIR_ADDR_STATUS_TWO:  rd_data_next = status_two;
					CSIR_ADDR_FLAGS:       rd_data_next = {flags_rsvd_reg, flags_reg};
					CSIR_ADDR_ENABLES:     rd_data_next = {enables_rsvd_reg, enables_reg};
					default:               rd_data_next = 8'h00;
				endcase
			end
		end else begin
			rd_valid_next = rd_valid_reg;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rd_data_reg  <= 8'h00;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_data_reg  <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
		end
	end

	assign rd_data_out  = rd_data_reg;
	assign rd_valid_out = rd_valid_reg;

	// Interrupt follows flags and enables combinationally, so a clear withdraws it at once
	assign irq_out = |(flags_reg & enables_reg);

	// Current-limit source selection; start-up limit overrides everything
	always_comb begin
		if (!st.rail_settled) begin
			limit_mode_out = CSIR_LIM_STARTUP_100MA;
		end else if (limit_cfg_reg[CSIR_LIMIT_SRC_BIT]) begin
			limit_mode_out = CSIR_LIM_FIELD;
		end else if (st.limit_select_pin) begin
			limit_mode_out = CSIR_LIM_PIN_1500MA;
		end else begin
			limit_mode_out = CSIR_LIM_PIN_500MA;
		end
	end

	assign limit_field_out = limit_cfg_reg[2:0];

	// Instant-on policy: system load has priority unless the disable bit is set
	assign charge_disable_out = !special_reg[CSIR_INST_ON_DIS_BIT] && st.system_rail_low;
	assign charge_reduce_out  = special_reg[CSIR_INST_ON_DIS_BIT] && st.system_rail_low
	                            && st.input_limiting_active;
	assign prereg_run_out     = !st.undervoltage_lockout;
endmodule // csir_regs
`default_nettype wire

// File: logic/csir_pkg.sv
// Package for the charger status and event register group.
// Assumes a single 250 MHz clock domain and an 8-bit local register port.
`default_nettype none
package csir_pkg;
	// Local register addresses
	localparam logic [15:0] CSIR_ADDR_LIMIT_CFG   = 16'hA090;
	localparam logic [15:0] CSIR_ADDR_SPECIAL_CTL = 16'hA094;
	localparam logic [15:0] CSIR_ADDR_STATUS_ONE  = 16'hA095;
	localparam logic [15:0] CSIR_ADDR_STATUS_TWO  = 16'hA096;
	localparam logic [15:0] CSIR_ADDR_FLAGS       = 16'hA097;
	localparam logic [15:0] CSIR_ADDR_ENABLES     = 16'hA098;
	localparam logic [15:0] CSIR_ADDR_RSVD_FIRST  = 16'hA099;
	localparam logic [15:0] CSIR_ADDR_RSVD_LAST   = 16'hA09F;

	// Field positions
	localparam int CSIR_LIMIT_SRC_BIT     = 7;
	localparam int CSIR_INST_ON_DIS_BIT   = 5;
	localparam int CSIR_ST1_ADAPTER_BIT   = 0;
	localparam int CSIR_ST1_LIMITING_BIT  = 7;
	localparam int CSIR_ST2_SWELL_BIT     = 0;
	localparam int CSIR_ST2_THERM_OFF_BIT = 1;
	localparam int CSIR_ST2_IN_PROG_BIT   = 4;
	localparam int CSIR_ST2_COMPLETE_BIT  = 5;
	localparam int CSIR_ST2_RAIL_LOW_BIT  = 6;
	localparam int CSIR_ST2_OVERHEAT_BIT  = 7;
	localparam int CSIR_FLAG_ADAPTER_BIT  = 0;
	localparam int CSIR_FLAG_LIMIT_BIT    = 1;
	localparam int CSIR_FLAG_COMPLETE_BIT = 2;

	// Values after reset, and the synchroniser stage count
	localparam logic [7:0] CSIR_LIMIT_CFG_RESET   = 8'h00;
	localparam logic [7:0] CSIR_SPECIAL_CTL_RESET = 8'h00;
	localparam logic [2:0] CSIR_FLAGS_RESET       = 3'h0;
	localparam logic [2:0] CSIR_ENABLES_RESET     = 3'h1;
	localparam logic [4:0] CSIR_RSVD_RESET        = 5'h00;
	localparam int         CSIR_SYNC_STAGES       = 2;

	// Input current limit selection
	typedef enum logic [1:0] {
		CSIR_LIM_STARTUP_100MA,
		CSIR_LIM_PIN_500MA,
		CSIR_LIM_PIN_1500MA,
		CSIR_LIM_FIELD
	} csir_limit_mode_t;

	// Live analog status levels, all asynchronous to clk_in
	typedef struct packed {
		logic swell_guard_discharging;
		logic thermistor_sense_off;
		logic charge_in_progress;
		logic charge_complete;
		logic system_rail_low;
		logic die_overheat;
		logic adapter_present;
		logic input_limiting_active;
		logic limit_select_pin;
		logic rail_settled;
		logic undervoltage_lockout;
	} csir_status_t;

	localparam int CSIR_STATUS_W = $bits(csir_status_t);

	// Local register port request
	typedef struct packed {
		logic [15:0] addr;
		logic        wr_en;
		logic        rd_en;
		logic [7:0]  wr_data;
	} csir_req_t;
endpackage
`default_nettype wire

// File: dv/csir_regs_assertions.sv
// Checker for the charger register group: port-level timing relations.
// Assumes it is bound to csir_regs and that ce_in is mostly held high.
`timescale 1ns/1ps
`default_nettype none
module csir_regs_assertions (
	input wire logic                       clk_in,             // Clock
	input wire logic                       arst_n_in,          // Async reset, active low
	input wire logic                       ce_in,              // Clock enable
	input wire csir_pkg::csir_status_t     status_in,          // Raw status levels
	input wire csir_pkg::csir_req_t        req_in,             // Register request
	input wire logic [7:0]                 rd_data_out,        // Read data
	input wire logic                       rd_valid_out,       // Read valid
	input wire logic                       irq_out,            // Interrupt request
	input wire csir_pkg::csir_limit_mode_t limit_mode_out,     // Limit source
	input wire logic [2:0]                 limit_field_out,    // Limit field
	input wire logic                       charge_disable_out, // Charge off
	input wire logic                       charge_reduce_out,  // Charge reduced
	input wire logic                       prereg_run_out      // Pre-regulator run
);
	import csir_pkg::*;
	logic [1:0] up_reg;
	logic [1:0] up_next;
	logic       ok;
	// Run of ce-high edges; the level checks need both sync flops filled
	always_comb begin
		up_next = ce_in ? up_reg + {1'b0, up_reg != 2'h3} : 2'h0;
	end
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			up_reg <= 2'h0;
		else
			up_reg <= up_next;
	end
	assign ok = up_reg == 2'h3;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	chk_read_answer: assert property (
		ce_in |=> rd_valid_out == $past(req_in.rd_en)) else $error("read valid wrong");
	chk_rsvd_zero: assert property (
		req_in.rd_en && ce_in && req_in.addr >= CSIR_ADDR_RSVD_FIRST && req_in.addr <= CSIR_ADDR_RSVD_LAST
		|=> rd_data_out == 8'h00) else $error("reserved read not zero");
	chk_disable_rail: assert property (
		ok && charge_disable_out |-> $past(status_in.system_rail_low, 2) && !charge_reduce_out)
		else $error("charge disabled without low rail");
	chk_reduce_cause: assert property (
		ok && charge_reduce_out |-> $past(status_in.system_rail_low, 2) && $past(status_in.input_limiting_active, 2))
		else $error("charge reduced without cause");
	chk_prereg_undervoltage_lockout: assert property (
		ok |-> prereg_run_out == !$past(status_in.undervoltage_lockout, 2)) else $error("pre-regulator run wrong");
	chk_startup_limit: assert property (
		ok && !$past(status_in.rail_settled, 2) |-> limit_mode_out == CSIR_LIM_STARTUP_100MA)
		else $error("start-up limit missing");
	chk_pin_limit: assert property (
		ok && $past(status_in.rail_settled, 2) && limit_mode_out != CSIR_LIM_FIELD |-> limit_mode_out ==
		($past(status_in.limit_select_pin, 2) ? CSIR_LIM_PIN_1500MA : CSIR_LIM_PIN_500MA))
		else $error("pin limit wrong");
	chk_irq_hold: assert property (
		ce_in && !req_in.wr_en && irq_out |=> irq_out) else $error("interrupt dropped without write");
	cov_irq: cover property (irq_out);
	cov_reduce: cover property (charge_reduce_out);
	cov_field: cover property (limit_mode_out == CSIR_LIM_FIELD);
endmodule // csir_regs_assertions
`default_nettype wire

// File: dv/csir_analog_model.sv
// Analog front end model that drives the charger status levels.
// Assumes the bench states wanted levels; they reach the pins off the clock edge.
`timescale 1ns/1ps
`default_nettype none
module csir_analog_model (
	input  wire csir_pkg::csir_status_t want_in,   // Levels asked for
	output wire csir_pkg::csir_status_t status_out // Levels at the pins
);
	import csir_pkg::*;
	// Comparators settle late and unrelated to the clock
	assign #1.3 status_out = want_in;
endmodule // csir_analog_model
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the charger status and event register group.
// Assumes csir_regs under logic/, the analog model and checker under dv/.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, s, e) begin check_count++; if ((s) !== (e)) begin fails++; $display("Error %s expected %h seen %h", n, e, s); end end
module tb;
	import csir_pkg::*;
	logic clk_in, arst_n_in, ce_in, rd_valid, irq, dis, red, run;
	logic [7:0] rd_data;
	logic [2:0] field;
	csir_status_t want, status;
	csir_req_t req;
	csir_limit_mode_t mode;
	int fails;
	int check_count;
	csir_analog_model u_model (.want_in(want), .status_out(status));
	csir_regs dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in), .status_in(status), .req_in(req),
		.rd_data_out(rd_data), .rd_valid_out(rd_valid), .irq_out(irq), .limit_mode_out(mode),
		.limit_field_out(field), .charge_disable_out(dis), .charge_reduce_out(red), .prereg_run_out(run));
	// Write strobe drops a cycle later, so back-to-back calls never collide
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1;
		req = '{a, 1'b1, 1'b0, d};
		@(posedge clk_in);
		#1;
		req.wr_en = 1'b0;
	endtask
	// Answer is looked at in the one cycle that valid stands
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk_in);
		#1;
		req = '{a, 1'b0, 1'b1, 8'h00};
		@(posedge clk_in);
		#1;
		req.rd_en = 1'b0;
		`CHK("rd_valid", rd_valid, 1'b1)
		`CHK("rd_data", rd_data, e)
	endtask
	// Two sync flops and the flag edge, with margin for the pin delay
	task automatic pins(input csir_status_t s);
		want = s;
		repeat (5) @(posedge clk_in);
		#1;
	endtask
	task automatic summarize();
		$display("Checks %0d, errors %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	// Watchdog in case the sequence stalls
	initial begin
		repeat (20000) @(posedge clk_in);
		fails++;
		summarize();
	end
	initial begin
		csir_status_t s;
		fails = 0;
		check_count = 0;
		arst_n_in = 1'b0;
		ce_in = 1'b1;
		req = '0;
		want = '0;
		s = '0;
		repeat (8) @(posedge clk_in);
		#1;
		arst_n_in = 1'b1;
		pins(s);
		rd(CSIR_ADDR_FLAGS, 8'h00);
		rd(CSIR_ADDR_ENABLES, 8'h01);
		rd(CSIR_ADDR_RSVD_FIRST, 8'h00);
		rd(CSIR_ADDR_RSVD_LAST, 8'h00);
		`CHK("startup_mode", mode, CSIR_LIM_STARTUP_100MA)
		`CHK("prereg_run", run, 1'b1)
		s.thermistor_sense_off = 1'b1;
		s.charge_in_progress = 1'b1;
		s.die_overheat = 1'b1;
		pins(s);
		rd(CSIR_ADDR_STATUS_TWO, 8'h92);
		s = '0;
		s.swell_guard_discharging = 1'b1;
		s.charge_complete = 1'b1;
		s.system_rail_low = 1'b1;
		pins(s);
		rd(CSIR_ADDR_STATUS_TWO, 8'h61);
		`CHK("charge_off", dis, 1'b1)
		wr(CSIR_ADDR_STATUS_TWO, 8'hFF);
		rd(CSIR_ADDR_STATUS_TWO, 8'h61);
		rd(CSIR_ADDR_FLAGS, 8'h04);
		`CHK("irq_masked", irq, 1'b0)
		wr(CSIR_ADDR_ENABLES, 8'h07);
		`CHK("irq_on", irq, 1'b1)
		wr(CSIR_ADDR_FLAGS, 8'h00);
		rd(CSIR_ADDR_FLAGS, 8'h04);
		wr(CSIR_ADDR_FLAGS, 8'h04);
		`CHK("irq_off", irq, 1'b0)
		s = '0;
		pins(s);
		rd(CSIR_ADDR_FLAGS, 8'h00);
		// Each source toggled up then down; both edges must flag
		for (int i = 0; i < 4; i++) begin
			if (i[0])
				s.input_limiting_active = ~s.input_limiting_active;
			else
				s.adapter_present = ~s.adapter_present;
			pins(s);
			rd(CSIR_ADDR_STATUS_ONE, {s.input_limiting_active, 6'h00, s.adapter_present});
			rd(CSIR_ADDR_FLAGS, i[0] ? 8'h02 : 8'h01);
			`CHK("irq_event", irq, 1'b1)
			wr(CSIR_ADDR_FLAGS, 8'h07);
		end
		s.input_limiting_active = 1'b1;
		pins(s);
		wr(CSIR_ADDR_ENABLES, 8'h05);
		`CHK("irq_disabled", irq, 1'b0)
		s.rail_settled = 1'b1;
		pins(s);
		`CHK("pin_low", mode, CSIR_LIM_PIN_500MA)
		s.limit_select_pin = 1'b1;
		pins(s);
		`CHK("pin_high", mode, CSIR_LIM_PIN_1500MA)
		wr(CSIR_ADDR_LIMIT_CFG, 8'h85);
		`CHK("field_mode", mode, CSIR_LIM_FIELD)
		`CHK("field", field, 3'h5)
		wr(CSIR_ADDR_LIMIT_CFG, 8'h05);
		`CHK("pin_again", mode, CSIR_LIM_PIN_1500MA)
		wr(CSIR_ADDR_SPECIAL_CTL, 8'h20);
		s.system_rail_low = 1'b1;
		pins(s);
		`CHK("reduce", red, 1'b1)
		`CHK("no_disable", dis, 1'b0)
		s.undervoltage_lockout = 1'b1;
		pins(s);
		`CHK("prereg_halt", run, 1'b0)
		// Writes made while the clock enable is low must leave no trace
		ce_in = 1'b0;
		wr(CSIR_ADDR_ENABLES, 8'h00);
		ce_in = 1'b1;
		rd(CSIR_ADDR_ENABLES, 8'h05);
		// Reset in mid-run with levels high: no flag from power-up levels, defaults back
		s.adapter_present = 1'b1;
		s.charge_complete = 1'b1;
		s.undervoltage_lockout = 1'b0;
		pins(s);
		arst_n_in = 1'b0;
		#1;
		`CHK("reset_mode", mode, CSIR_LIM_STARTUP_100MA)
		repeat (8) @(posedge clk_in);
		#1;
		arst_n_in = 1'b1;
		pins(s);
		rd(CSIR_ADDR_FLAGS, 8'h00);
		rd(CSIR_ADDR_ENABLES, 8'h01);
		rd(CSIR_ADDR_LIMIT_CFG, 8'h00);
		`CHK("reset_pin", mode, CSIR_LIM_PIN_1500MA)
		`CHK("reset_off", dis, 1'b1)
		summarize();
	end
endmodule // tb
bind csir_regs csir_regs_assertions u_chk (.clk_in, .arst_n_in, .ce_in, .status_in, .req_in, .rd_data_out,
	.rd_valid_out, .irq_out, .limit_mode_out, .limit_field_out, .charge_disable_out, .charge_reduce_out,
	.prereg_run_out);
`default_nettype wire
